// ---- src/cpu_bus_control.sv ----
// bus sequencer with halt, wait, interrupt, restart and on-chip RAM
`timescale 1ns/1ps
module cpu_bus_control #(
	parameter int BUS_DIV = cpu_bus_pkg::BUS_CLK_DIV,
	parameter int RAM_DEPTH = cpu_bus_pkg::RAM_BYTES
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic haltN,
	input wire logic irqN,
	input wire logic nmiN,
	input wire logic resetN,
	input wire logic onchipRamEnable,
	input wire logic [7:0] dataIn,
	output logic [7:0] dataOut,
	output logic dataOeN,
	output logic [15:0] address,
	output logic readWrite,
	output logic validAddressStrobe,
	output logic busAvailable,
	output logic busClock,
	input wire cpu_bus_pkg::coreReq_t coreReq,
	input wire cpu_bus_pkg::cpuRegs_t cpuRegs,
	input wire cpu_bus_pkg::maskWrite_t maskWrite,
	output cpu_bus_pkg::coreResp_t coreResp,
	output logic maskFlag,
	output logic [7:0] ccrView
);
	import cpu_bus_pkg::*;

	localparam int RAM_AW = $clog2(RAM_DEPTH);

	logic [4:0] pinS;
	logic [7:0] dataInS;
	logic haltS, irqS, nmiS, resetS, ramEnS;
	logic eFall;

	state_t state;
	intSrc_t src;
	logic [2:0] stkIdx;
	logic curRam, curCore, curLast, curSwi, curWai;
	logic [7:0] vecHi;
	logic nmiPrev, nmiPending, irqSampled;
	logic [7:0] ram [RAM_DEPTH];

	decision_t tgt, dec, decHalt;
	logic [2:0] next_stkIdx, pushIdx;
	logic [15:0] next_addr;
	logic next_rw, next_vma, next_core, next_last, next_swi, next_wai, next_drive, next_ba, next_ram;
	logic [7:0] next_wdata;
	logic [7:0] readByte;
	logic inReset, nmiEdge, nmiTaken, vecEntry;

	pin_sync #(.WIDTH(5), .RESET_VALUE(5'h1F)) uPinSync (
		.clk(clk),
		.rst(rst),
		.pinIn({haltN, irqN, nmiN, resetN, onchipRamEnable}),
		.syncOut(pinS)
	);

	pin_sync #(.WIDTH(8), .RESET_VALUE(8'h00)) uDataSync (
		.clk(clk),
		.rst(rst),
		.pinIn(dataIn),
		.syncOut(dataInS)
	);

	bus_phase #(.DIV(BUS_DIV)) uPhase (
		.clk(clk),
		.rst(rst),
		.eLevel(busClock),
		.eFall(eFall)
	);

	assign {haltS, irqS, nmiS, resetS, ramEnS} = pinS;
	assign inReset = rst || !resetS;

	function automatic decision_t decide(input logic swi, input logic wai, input logic haltLow,
		input logic nmi, input logic irq, input logic mask);
		decision_t d;
		d.st = ST_RUN;
		d.src = SRC_NONE;
		if (swi) begin
			d = '{ST_STACK, SRC_SWI};
		end else if (wai) begin
			d = '{ST_STACK, SRC_WAIT};
		end else if (haltLow) begin
			d = '{ST_HALT, SRC_NONE};
		end else if (nmi) begin
			d = '{ST_STACK, SRC_NMI};
		end else if (irq && !mask) begin
			d = '{ST_STACK, SRC_IRQ};
		end
		return d;
	endfunction : decide

	function automatic logic [15:0] vectorOf(input intSrc_t s);
		logic [15:0] v;
		unique case (s)
			SRC_IRQ: v = VEC_IRQ;
			SRC_SWI: v = VEC_SWI;
			SRC_NMI: v = VEC_NMI;
			default: v = VEC_RESET;
		endcase
		return v;
	endfunction : vectorOf

	// bytes go out low PC first, flags last
	function automatic logic [7:0] stackByte(input logic [2:0] idx, input cpuRegs_t r, input logic [7:0] cc);
		logic [7:0] v;
		unique case (idx)
			3'h0: v = r.pc[7:0];
			3'h1: v = r.pc[15:8];
			3'h2: v = r.x[7:0];
			3'h3: v = r.x[15:8];
			3'h4: v = r.a;
			3'h5: v = r.b;
			default: v = cc;
		endcase
		return v;
	endfunction : stackByte

	always_comb begin
		ccrView = cpuRegs.ccr | CCR_ONES;
		ccrView[CCR_MASK_BIT] = maskFlag;
	end

	// on-chip RAM read data was placed on dataOut at launch
	assign readByte = curRam ? dataOut : dataInS;

	assign dec = decide(curSwi, curWai, !haltS, nmiPending, irqSampled, maskFlag);
	assign decHalt = decide(1'b0, 1'b0, !haltS, nmiPending, irqSampled, maskFlag);

	// where to go at the end of the running bus cycle
	always_comb begin
		tgt = '{ST_RUN, SRC_NONE};
		unique case (state)
			ST_RESET: tgt = resetS ? '{ST_VEC_HI, SRC_RESET} : '{ST_RESET, SRC_RESET};
			ST_RUN: tgt = curLast ? dec : '{ST_RUN, SRC_NONE};
			ST_HALT: tgt = haltS ? decHalt : '{ST_HALT, SRC_NONE};
			ST_STACK: begin
				if (stkIdx == STACK_LAST) begin
					tgt = (src == SRC_WAIT) ? '{ST_WAIT, SRC_WAIT} : '{ST_VEC_HI, src};
				end else begin
					tgt = '{ST_STACK, src};
				end
			end
			ST_WAIT: begin
				if (nmiPending) begin
					tgt = '{ST_VEC_HI, SRC_NMI};
				end else if (irqSampled && !maskFlag) begin
					tgt = '{ST_VEC_HI, SRC_IRQ};
				end else begin
					tgt = '{ST_WAIT, SRC_WAIT};
				end
			end
			ST_VEC_HI: tgt = '{ST_VEC_LO, src};
			ST_VEC_LO: tgt = '{ST_RUN, SRC_NONE};
		endcase
	end

	// shape of the next bus cycle
	always_comb begin
		pushIdx = (state == ST_STACK) ? 3'(stkIdx + 3'h1) : 3'h0;
		next_stkIdx = stkIdx;
		next_addr = address;
		next_rw = 1'b1;
		next_vma = 1'b0;
		next_core = 1'b0;
		next_last = 1'b0;
		next_swi = 1'b0;
		next_wai = 1'b0;
		next_wdata = dataOut;
		next_drive = 1'b0;
		next_ba = 1'b0;
		unique case (tgt.st)
			ST_RESET: next_addr = RESET_HOLD_ADDR;
			ST_RUN: begin
				if (state == ST_VEC_LO) begin
					next_addr = {vecHi, readByte};
				end else begin
					next_core = 1'b1;
					next_addr = coreReq.valid ? coreReq.addr : cpuRegs.pc;
					next_vma = coreReq.valid;
					next_rw = !(coreReq.valid && coreReq.write);
					next_drive = coreReq.valid && coreReq.write;
					next_wdata = coreReq.wdata;
					next_last = coreReq.last;
					next_swi = coreReq.swi;
					next_wai = coreReq.wai;
				end
			end
			ST_HALT: begin
				next_addr = cpuRegs.pc;
				next_ba = 1'b1;
			end
			ST_STACK: begin
				next_stkIdx = pushIdx;
				next_addr = 16'(cpuRegs.sp - {13'h0000, pushIdx});
				next_vma = 1'b1;
				next_rw = 1'b0;
				next_drive = 1'b1;
				next_wdata = stackByte(pushIdx, cpuRegs, ccrView);
			end
			ST_WAIT: next_ba = 1'b1;
			ST_VEC_HI: begin
				next_addr = vectorOf(tgt.src);
				next_vma = 1'b1;
			end
			ST_VEC_LO: begin
				next_addr = 16'(vectorOf(tgt.src) + 16'h0001);
				next_vma = 1'b1;
			end
		endcase
		next_ram = next_vma && ramEnS && (next_addr <= RAM_TOP);
	end

	// sequencer and bus pins, stepped once per bus cycle
	always_ff @(posedge clk) begin
		if (inReset) begin
			state <= ST_RESET;
			src <= SRC_RESET;
			stkIdx <= 3'h0;
			address <= RESET_HOLD_ADDR;
			readWrite <= 1'b1;
			validAddressStrobe <= 1'b0;
			busAvailable <= 1'b0;
			dataOeN <= 1'b1;
			dataOut <= 8'h00;
			curRam <= 1'b0;
			curCore <= 1'b0;
			curLast <= 1'b0;
			curSwi <= 1'b0;
			curWai <= 1'b0;
		end else if (eFall) begin
			state <= tgt.st;
			src <= tgt.src;
			stkIdx <= next_stkIdx;
			address <= next_addr;
			readWrite <= next_rw;
			validAddressStrobe <= next_vma;
			busAvailable <= next_ba;
			dataOeN <= !(next_drive || next_ram);
			if (next_drive) begin
				dataOut <= next_wdata;
			end else if (next_ram) begin
				// a write to the same byte finishing now is not in the array yet
				if (curRam && !readWrite && address == next_addr) begin
					dataOut <= dataOut;
				end else begin
					dataOut <= ram[next_addr[RAM_AW-1:0]];
				end
			end
			curRam <= next_ram;
			curCore <= next_core;
			curLast <= next_last;
			curSwi <= next_swi;
			curWai <= next_wai;
		end
	end

	// on-chip RAM write at the close of the bus cycle
	always_ff @(posedge clk) begin
		if (!inReset && eFall && curRam && !readWrite) begin
			ram[address[RAM_AW-1:0]] <= dataOut;
		end
	end

	// interrupt inputs are looked at only while the bus clock is high
	assign nmiEdge = busClock && nmiPrev && !nmiS;
	assign vecEntry = eFall && tgt.st == ST_VEC_HI && state != ST_VEC_HI;
	assign nmiTaken = vecEntry && tgt.src == SRC_NMI;

	always_ff @(posedge clk) begin
		if (inReset) begin
			nmiPrev <= 1'b1;
			irqSampled <= 1'b0;
		end else if (busClock) begin
			nmiPrev <= nmiS;
			irqSampled <= !irqS;
		end
	end

	// a new edge in the clearing cycle keeps the request alive
	always_ff @(posedge clk) begin
		if (inReset) begin
			nmiPending <= 1'b0;
		end else if (nmiEdge) begin
			nmiPending <= 1'b1;
		end else if (nmiTaken) begin
			nmiPending <= 1'b0;
		end
	end

	// hardware set outranks a core write in the same cycle
	always_ff @(posedge clk) begin
		if (inReset) begin
			maskFlag <= 1'b1;
		end else if (vecEntry) begin
			maskFlag <= 1'b1;
		end else if (maskWrite.valid) begin
			maskFlag <= maskWrite.value;
		end
	end

	// answers toward the instruction core
	always_ff @(posedge clk) begin
		if (inReset) begin
			coreResp.done <= 1'b0;
			coreResp.rdata <= 8'h00;
			coreResp.pcLoad <= 1'b0;
			coreResp.pc <= 16'h0000;
			coreResp.stackDone <= 1'b0;
			vecHi <= 8'h00;
		end else begin
			coreResp.done <= eFall && state == ST_RUN && curCore;
			coreResp.pcLoad <= eFall && state == ST_VEC_LO;
			coreResp.stackDone <= eFall && state == ST_STACK && stkIdx == STACK_LAST;
			if (eFall && state == ST_RUN && curCore) begin
				coreResp.rdata <= readByte;
			end
			if (eFall && state == ST_VEC_HI) begin
				vecHi <= readByte;
			end
			if (eFall && state == ST_VEC_LO) begin
				coreResp.pc <= {vecHi, readByte};
			end
		end
	end

	assign coreResp.take = eFall && !inReset && next_core;

endmodule : cpu_bus_control

// ---- src/cpu_bus_pkg.sv ----
// shared types and constants for the processor bus, interrupt and restart controller
// Summary of operation
// - Address bus always driven, never released.
// - Eight-bit data bus with switchable output drivers.
// - On-chip RAM access drives data bus outward.
// - Halt low stops at boundary, shows next address.
// - Read/write high for reads, idle, halted.
// - Valid-address strobe only for meaningful addresses.
// - Bus-available high when halted or waiting.
// - Wait ends on NMI or unmasked IRQ.
// - Unmasked IRQ stacks state after instruction.
// - IRQ sets mask, vectors via FFF8/FFF9.
// - No service while halted; NMI edge latched, IRQ level resampled each cycle.
// - Reset low idles; restart fetches FFFE/FFFF.
// - Restart sets the interrupt mask.
// - NMI falling edge served regardless of mask.
// - NMI stacks state, vectors via FFFC/FFFD.
// - Interrupt inputs sampled while bus clock high.
// - Mask in flag bit 4; bits 7,6 ones.
// - On-chip RAM responds only while enabled.
package cpu_bus_pkg;

	localparam int CLK_PERIOD_NS = 5;
	localparam int BUS_CYCLE_NS = 1000;
	localparam int BUS_CLK_DIV = BUS_CYCLE_NS / CLK_PERIOD_NS;

	localparam int RAM_BYTES = 128;
	localparam logic [15:0] RAM_TOP = 16'h007F;

	localparam logic [15:0] VEC_IRQ = 16'hFFF8;
	localparam logic [15:0] VEC_SWI = 16'hFFFA;
	localparam logic [15:0] VEC_NMI = 16'hFFFC;
	localparam logic [15:0] VEC_RESET = 16'hFFFE;
	localparam logic [15:0] RESET_HOLD_ADDR = 16'hFFFE;

	localparam int CCR_MASK_BIT = 4;
	localparam logic [7:0] CCR_ONES = 8'hC0;

	localparam logic [2:0] STACK_LAST = 3'h6;

	typedef enum {ST_RESET, ST_RUN, ST_HALT, ST_STACK, ST_WAIT, ST_VEC_HI, ST_VEC_LO} state_t;
	typedef enum {SRC_NONE, SRC_RESET, SRC_NMI, SRC_IRQ, SRC_SWI, SRC_WAIT} intSrc_t;

	typedef struct packed {
		state_t st;
		intSrc_t src;
	} decision_t;

	typedef struct packed {
		logic valid;
		logic write;
		logic last;
		logic swi;
		logic wai;
		logic [15:0] addr;
		logic [7:0] wdata;
	} coreReq_t;

	typedef struct packed {
		logic [15:0] pc;
		logic [15:0] x;
		logic [15:0] sp;
		logic [7:0] a;
		logic [7:0] b;
		logic [7:0] ccr;
	} cpuRegs_t;

	typedef struct packed {
		logic valid;
		logic value;
	} maskWrite_t;

	typedef struct packed {
		logic take;
		logic done;
		logic [7:0] rdata;
		logic pcLoad;
		logic [15:0] pc;
		logic stackDone;
	} coreResp_t;

endpackage : cpu_bus_pkg

// ---- src/pin_sync.sv ----
// two-stage synchroniser for asynchronous pins
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VALUE = '1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] syncOut
);
	logic [WIDTH-1:0] stage1;

	// stage1 feeds only the second flop
	always_ff @(posedge clk) begin
		if (rst) begin
			stage1 <= RESET_VALUE;
			syncOut <= RESET_VALUE;
		end else begin
			stage1 <= pinIn;
			syncOut <= stage1;
		end
	end
endmodule : pin_sync

// ---- src/bus_phase.sv ----
// bus clock generator: divides clk into the single-phase bus clock
`timescale 1ns/1ps
module bus_phase #(
	parameter int DIV = 200
) (
	input wire logic clk,
	input wire logic rst,
	output logic eLevel,
	output logic eFall
);
	localparam int CW = $clog2(DIV);
	localparam logic [CW-1:0] CNT_LAST = CW'(DIV - 1);
	localparam logic [CW-1:0] CNT_HALF = CW'(DIV / 2);

	logic [CW-1:0] cnt;
	logic [CW-1:0] next_cnt;

	assign next_cnt = (cnt == CNT_LAST) ? '0 : CW'(cnt + 1'b1);

	always_ff @(posedge clk) begin
		if (rst) begin
			cnt <= '0;
		end else begin
			cnt <= next_cnt;
		end
	end

	// low first half, high second half; eFall marks the cycle end
	always_ff @(posedge clk) begin
		if (rst) begin
			eLevel <= 1'b0;
			eFall <= 1'b0;
		end else begin
			eLevel <= (next_cnt >= CNT_HALF);
			eFall <= (cnt == CNT_LAST);
		end
	end
endmodule : bus_phase

// ---- verif/bus_control_props.sv ----
// checker for bus, vector and restart behaviour at the controller ports
`timescale 1ns/1ps
module bus_control_props #(
	parameter int BUS_DIV = 8
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic onchipRamEnable,
	input wire logic dataOeN,
	input wire logic [15:0] address,
	input wire logic readWrite,
	input wire logic validAddressStrobe,
	input wire logic busAvailable,
	input wire logic busClock,
	input wire cpu_bus_pkg::coreResp_t coreResp,
	input wire logic maskFlag,
	input wire logic [7:0] ccrView
);
	import cpu_bus_pkg::*;
	localparam int GAP = 2 * BUS_DIV + 4;
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	sequence fetch(logic [15:0] a);
		validAddressStrobe && address == a;
	endsequence
	// mid-cycle look: enable sync and launch have both settled by then
	sequence midRead;
		$rose(busClock) && validAddressStrobe && readWrite;
	endsequence
	AST_RESET_STATE: assert property (disable iff (1'b0)
		rst |=> address == 16'hFFFE && readWrite && !validAddressStrobe && dataOeN && maskFlag)
		else $error("reset outputs wrong");
	AST_CCR_BITS: assert property (ccrView[7:6] == 2'b11 && ccrView[4] == maskFlag)
		else $error("flag view bits wrong");
	AST_RELEASED_BUS: assert property (busAvailable |-> !validAddressStrobe && readWrite && dataOeN)
		else $error("bus not idle while released");
	// a take at the edge that ends a halt is legal; the cycle it launches must not be released
	AST_NO_TAKE_RELEASED: assert property (coreResp.take |=> !busAvailable)
		else $error("request taken while released");
	AST_WRITE_DRIVES: assert property (validAddressStrobe && !readWrite |-> !dataOeN)
		else $error("write without driving data");
	AST_RAM_ON: assert property (onchipRamEnable [*8] ##0 midRead ##0 address <= RAM_TOP |-> !dataOeN)
		else $error("on-chip read not driven");
	AST_RAM_OFF: assert property ((!onchipRamEnable) [*8] ##0 midRead |-> dataOeN)
		else $error("disabled ram drives bus");
	AST_IRQ_VEC: assert property (fetch(VEC_IRQ) |-> maskFlag ##[1:GAP] fetch(16'hFFF9))
		else $error("maskable vector pair wrong");
	AST_NMI_VEC: assert property (fetch(VEC_NMI) |-> ##[1:GAP] fetch(16'hFFFD))
		else $error("non-maskable vector pair wrong");
	AST_RESTART_VEC: assert property (fetch(VEC_RESET) |-> ##[1:GAP] fetch(16'hFFFF) ##[1:GAP] coreResp.pcLoad)
		else $error("restart fetch wrong");
endmodule : bus_control_props

// ---- verif/ext_memory.sv ----
// external memory and system decode on the far side of the data bus
`timescale 1ns/1ps
module ext_memory (
	input wire logic clk,
	input wire logic [15:0] address,
	input wire logic validAddressStrobe,
	input wire logic readWrite,
	input wire logic onchipRamEnable,
	input wire logic dataOeN,
	input wire logic [7:0] dataOut,
	output logic [7:0] dataIn
);
	logic [7:0] drive;
	logic selected;
	initial drive = 8'hA5;
	assign selected = validAddressStrobe && readWrite && !(onchipRamEnable && address <= 16'h007F);
	// deselected bus toggles so a stale byte never passes for read data
	always @(posedge clk) drive <= selected ? address[7:0] + address[15:8] : ~drive;
	assign dataIn = dataOeN ? drive : dataOut;
endmodule : ext_memory

// ---- verif/cpu_bus_control_interrupt_reset_tb.sv ----
// self-checking bench for the bus, interrupt and restart controller
`timescale 1ns/1ps
`define CHECK(what, exp, got) begin samplesChecked++; if ((got) !== (exp)) begin errTotal++; \
	$display("mismatch %s expected %h seen %h", what, exp, got); end end
module cpu_bus_control_interrupt_reset_tb;
	import cpu_bus_pkg::*;
	localparam int DIV = 8;
	logic clk = 0, rst = 1, haltN = 1, irqN = 1, nmiN = 1, resetN = 1, onchipRamEnable = 1;
	logic [7:0] dataIn, dataOut, ccrView, d;
	logic [15:0] address, a;
	logic dataOeN, readWrite, validAddressStrobe, busAvailable, busClock, maskFlag, lastE, flip;
	coreReq_t coreReq;
	cpuRegs_t cpuRegs;
	maskWrite_t maskWrite;
	coreResp_t coreResp;
	logic [8:0] expQ[$];
	logic [15:0] pcQ[$];
	logic [23:0] wrQ[$];
	logic [8:0] pendExp, e;
	logic [15:0] expPc;
	int errTotal = 0, samplesChecked = 0, cycles = 0, takes = 0, stacks = 0, tk0;
	cpu_bus_control #(.BUS_DIV(DIV)) dut (.clk, .rst, .haltN, .irqN, .nmiN, .resetN, .onchipRamEnable, .dataIn,
		.dataOut, .dataOeN, .address, .readWrite, .validAddressStrobe, .busAvailable, .busClock, .coreReq,
		.cpuRegs, .maskWrite, .coreResp, .maskFlag, .ccrView);
	ext_memory mem (.clk, .address, .validAddressStrobe, .readWrite, .onchipRamEnable, .dataOeN, .dataOut, .dataIn);
	initial forever #2.5 clk = ~clk;
	task automatic tallyAndFinish;
		$display("checks %0d mismatches %0d", samplesChecked, errTotal);
		if (errTotal == 0 && samplesChecked > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : tallyAndFinish
	// each take files the note that the driver left for it
	always @(posedge clk) begin
		lastE <= busClock;
		if (coreResp.take) begin
			expQ.push_back(pendExp);
			takes++;
		end
		if (coreResp.stackDone) stacks++;
		if (busClock && !lastE && validAddressStrobe && !readWrite) wrQ.push_back({address, dataOut});
		if (coreResp.done) begin
			e = expQ.pop_front();
			if (e[8]) `CHECK("read data", e[7:0], coreResp.rdata)
		end
		// pop once: the macro names its expected value twice
		if (coreResp.pcLoad) begin
			expPc = pcQ.pop_front();
			`CHECK("vector", expPc, coreResp.pc)
		end
		if (++cycles > 20000) begin
			errTotal++;
			tallyAndFinish();
		end
	end
	task automatic step(int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : step
	task automatic idle;
		coreReq = '0;
		coreReq.last = 1'b1;
		pendExp = '0;
	endtask : idle
	task automatic send(input coreReq_t r, input logic [8:0] x);
		coreReq = r;
		pendExp = x;
		#1;
		for (int i = 0; i < 100 && coreResp.take !== 1'b1; i++) step(1);
		step(1);
		idle();
	endtask : send
	task automatic waitVec;
		for (int i = 0; i < 400 && pcQ.size() > 0; i++) step(1);
		`CHECK("pending vectors", 0, pcQ.size())
	endtask : waitVec
	task automatic clearMask;
		maskWrite = '{1'b1, 1'b0};
		step(1);
		maskWrite = '0;
	endtask : clearMask
	initial begin
		cpuRegs = '0;
		maskWrite = '0;
		idle();
		void'($urandom(19));
		pcQ.push_back(16'hFDFE);
		step(8);
		rst = 0;
		waitVec();
		`CHECK("mask after restart", 1'b1, maskFlag)
		for (int i = 0; i < 6; i++) begin
			// kept below the vector page so no read looks like a vector fetch
			a = 16'h0100 | (16'($urandom) & 16'h7FFF);
			send('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, a, 8'h00}, {1'b1, a[7:0] + a[15:8]});
		end
		a = 16'($urandom) & 16'h007F;
		d = 8'($urandom);
		send('{1'b1, 1'b1, 1'b1, 1'b0, 1'b0, a, d}, 9'h000);
		send('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, a, 8'h00}, {1'b1, d});
		flip = 1'($urandom);
		// enable only moves once the previous read has finished on the wire
		for (int i = 0; i < 4; i++) begin
			onchipRamEnable = 1'(i) ^ flip;
			send('{1'b1, 1'b0, 1'b1, 1'b0, 1'b0, a, 8'h00}, {1'b1, onchipRamEnable ? d : a[7:0]});
			step(2 * DIV);
		end
		onchipRamEnable = 1;
		cpuRegs = 72'({$urandom, $urandom, $urandom});
		cpuRegs.sp = 16'h1F00;
		clearMask();
		wrQ.delete();
		pcQ.push_back(16'hF7F8);
		irqN = 0;
		waitVec();
		irqN = 1;
		`CHECK("stack count", 7, wrQ.size())
		`CHECK("stack done", 1, stacks)
		`CHECK("stacked pc low", {cpuRegs.sp, cpuRegs.pc[7:0]}, wrQ[0])
		`CHECK("stacked flags", {cpuRegs.sp - 16'h0006, (cpuRegs.ccr | 8'hC0) & 8'hEF}, wrQ[6])
		clearMask();
		haltN = 0;
		for (int i = 0; i < 100 && busAvailable !== 1'b1; i++) step(1);
		irqN = 0;
		step(3 * DIV);
		`CHECK("released", 1'b1, busAvailable)
		`CHECK("halt address", cpuRegs.pc, address)
		`CHECK("halt read level", 1'b1, readWrite)
		pcQ.push_back(16'hF7F8);
		haltN = 1;
		waitVec();
		irqN = 1;
		pcQ.push_back(16'hFBFC);
		nmiN = 0;
		step(2 * DIV);
		nmiN = 1;
		waitVec();
		pcQ.push_back(16'hF9FA);
		send('{1'b0, 1'b0, 1'b1, 1'b1, 1'b0, 16'h0000, 8'h00}, 9'h000);
		waitVec();
		clearMask();
		pcQ.push_back(16'hF7F8);
		send('{1'b0, 1'b0, 1'b1, 1'b0, 1'b1, 16'h0000, 8'h00}, 9'h000);
		for (int i = 0; i < 200 && busAvailable !== 1'b1; i++) step(1);
		`CHECK("wait released", 1'b1, busAvailable)
		irqN = 0;
		waitVec();
		irqN = 1;
		haltN = 0;
		for (int i = 0; i < 100 && busAvailable !== 1'b1; i++) step(1);
		for (int i = 0; i < DIV && busClock !== 1'b1; i++) step(1);
		tk0 = takes;
		haltN = 1;
		step(DIV);
		haltN = 0;
		step(3 * DIV);
		`CHECK("stepped cycles", tk0 + 1, takes)
		`CHECK("halted again", 1'b1, busAvailable)
		haltN = 1;
		resetN = 0;
		step(3 * DIV + 2);
		pcQ.push_back(16'hFDFE);
		resetN = 1;
		waitVec();
		`CHECK("mask after restart", 1'b1, maskFlag)
		tallyAndFinish();
	end
endmodule : cpu_bus_control_interrupt_reset_tb
bind cpu_bus_control bus_control_props #(.BUS_DIV(BUS_DIV)) props (.clk, .rst, .onchipRamEnable, .dataOeN,
	.address, .readWrite, .validAddressStrobe, .busAvailable, .busClock, .coreResp, .maskFlag, .ccrView);
